/* hdl/adct_pkg.sv */
// Purpose: constants for the converter timing control block
// Assumes: 32-bit APB, one aligned word per register
// Notes: offsets and layouts below are shared by design and bench
// Notes on behaviour
// - cpu clocked conversion takes 31 machine cycles
// - rc select bit clocks converter from rc
// - rc mode: 3-4 sync cycles plus 108-112 rc
// - power down on cpu clock aborts, no wake
// - idle completion with irq enabled wakes cpu
// - rc clocked conversion continues in power down
// - start blocked while busy or done set
// - done flag sticky, raises interrupt when enabled
package adct_pkg;
  // register byte offsets
  localparam logic [7:0] ADCT_CTRL_OFS = 8'h00;
  localparam logic [7:0] ADCT_RESULT_OFS = 8'h04;
  localparam logic [7:0] ADCT_STATUS_OFS = 8'h08;
  localparam logic [7:0] ADCT_MASK_OFS = 8'h0C;
  // control register fields
  localparam int ADCT_CH_LSB = 0;
  localparam int ADCT_RCSEL_BIT = 2;
  localparam int ADCT_START_BIT = 3;
  localparam int ADCT_DONE_BIT = 4;
  // status bits: done event, abort event
  localparam int ADCT_EV_DONE = 0;
  localparam int ADCT_EV_ABORT = 1;
  localparam logic [1:0] ADCT_MASK_RST = 2'h0;
  // timing counts
  localparam int ADCT_CPU_CYCLES = 31;
  localparam int ADCT_RC_CLOCKS = 108;
  localparam int ADCT_SYNC_MIN = 3;
  // result value left after an abort
  localparam logic [7:0] ADCT_BAD_RESULT = 8'hFF;
  // sequencer states, gray along idle-sync-run-done
  typedef enum logic [1:0] {
    ADCT_IDLE = 2'h0,
    ADCT_SYNC = 2'h1,
    ADCT_RUN = 2'h3,
    ADCT_FIN = 2'h2
  } adct_state_t;
endpackage : adct_pkg

/* hdl/adct_sar.sv */
// Purpose: successive approximation of one sample over 8 steps
// Assumes: analog compare modeled by the sampled 8-bit input word
// Notes: one step per tick; ticks come from the sequencer
`timescale 1ns/1ps
module adct_sar (
  // clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // control
  input wire logic load_i,
  input wire logic tick_i,
  input wire logic [7:0] sample_i,
  // result
  output logic [7:0] value_o
);
  logic [7:0] trial;  // bit under test
  logic [7:0] held;   // sample captured at start
  // one bit resolved per tick, msb first
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trial <= 8'h80;
      held <= 8'h00;
      value_o <= 8'h00;
    end else if (load_i) begin
      trial <= 8'h80;
      held <= sample_i;
      value_o <= 8'h00;
    end else if (tick_i && trial != 8'h00) begin
      // keep the bit when the trial level does not exceed the input
      if ((value_o | trial) <= held) begin
        value_o <= value_o | trial;
      end
      trial <= trial >> 1;
    end
  end
endmodule : adct_sar

/* hdl/adct_ctrl.sv */
// Purpose: converter control, timing and APB register file
// Assumes: rc_tick_i is a one-cycle pulse per rc clock, already synced
// Notes: machine cycle taken as one clock_i cycle
`timescale 1ns/1ps
module adct_ctrl #(
  parameter int CPU_CYCLES = adct_pkg::ADCT_CPU_CYCLES,
  parameter int RC_CLOCKS = adct_pkg::ADCT_RC_CLOCKS
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // analog inputs, digitised
  input wire logic [7:0] analog_in_0_i,
  input wire logic [7:0] analog_in_1_i,
  input wire logic [7:0] analog_in_2_i,
  input wire logic [7:0] analog_in_3_i,
  // rc oscillator tick and power modes
  input wire logic rc_tick_i,
  input wire logic idle_mode_i,
  input wire logic power_down_i,
  // outputs
  output logic wake_o,
  output logic irq_o
);
  logic [1:0] channel_select;      // input chooser
  logic adc_rc_clock_select;       // clock source
  logic conv_start_busy;           // start / busy
  logic conv_done_flag;            // completion flag
  logic [7:0] conv_result_reg;     // shared result
  logic [1:0] irq_status;          // sticky events
  logic [1:0] irq_mask;            // enables
  logic [7:0] cnt;                 // step counter
  logic [7:0] sample;              // chosen input
  logic [7:0] sar_value;           // approximation
  logic rc_mode;                   // latched source for this conversion
  logic wr_en, start_req, finish, abort_pd;
  logic [1:0] sel_now;             // channel for this cycle
  logic rc_now;                    // source for this cycle
  adct_pkg::adct_state_t state;
  adct_pkg::adct_state_t next_state;

  // apb: zero wait states, write at access phase, read data registered at setup phase
  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;
  assign wr_en = psel_i && penable_i && pwrite_i;

  // start only accepted when neither busy nor done is set
  assign start_req = wr_en && paddr_i == adct_pkg::ADCT_CTRL_OFS
    && pwdata_i[adct_pkg::ADCT_START_BIT]
    && !conv_start_busy && !conv_done_flag;

  // a start may carry its own channel and source in the same write;
  // the written values must apply to that very conversion
  assign sel_now = start_req ? pwdata_i[adct_pkg::ADCT_CH_LSB +: 2]
    : channel_select;
  assign rc_now = start_req ? pwdata_i[adct_pkg::ADCT_RCSEL_BIT]
    : adc_rc_clock_select;

  // power down kills a cpu-clocked conversion only
  assign abort_pd = power_down_i && !rc_mode
    && state != adct_pkg::ADCT_IDLE;
  assign finish = state == adct_pkg::ADCT_FIN;

  // input selection by the two-bit field
  always_comb begin
    case (sel_now)
      2'h0: sample = analog_in_0_i;
      2'h1: sample = analog_in_1_i;
      2'h2: sample = analog_in_2_i;
      default: sample = analog_in_3_i;
    endcase
  end

  // sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      adct_pkg::ADCT_IDLE: begin
        if (start_req) begin
          // rc mode goes through a sync phase first
          next_state = rc_now ? adct_pkg::ADCT_SYNC
                              : adct_pkg::ADCT_RUN;
        end
      end
      adct_pkg::ADCT_SYNC: begin
        if (cnt == 8'(adct_pkg::ADCT_SYNC_MIN - 1)) begin
          next_state = adct_pkg::ADCT_RUN;
        end
      end
      adct_pkg::ADCT_RUN: begin
        // cpu mode counts clocks, rc mode counts rc ticks
        if (!rc_mode && cnt == 8'(CPU_CYCLES - 2)) begin
          next_state = adct_pkg::ADCT_FIN;
        end else if (rc_mode && rc_tick_i
                     && cnt == 8'(RC_CLOCKS - 1)) begin
          next_state = adct_pkg::ADCT_FIN;
        end
      end
      adct_pkg::ADCT_FIN: next_state = adct_pkg::ADCT_IDLE;
      default: next_state = adct_pkg::ADCT_IDLE;
    endcase
    if (abort_pd) begin
      next_state = adct_pkg::ADCT_IDLE;
    end
  end

  // state and step counter
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= adct_pkg::ADCT_IDLE;
      cnt <= 8'h00;
      rc_mode <= 1'b0;
    end else begin
      state <= next_state;
      // latch the source with the start so it holds for the whole run
      if (start_req) begin
        rc_mode <= rc_now;
      end
      if (next_state != state) begin
        cnt <= 8'h00;
      end else if (state == adct_pkg::ADCT_SYNC) begin
        cnt <= cnt + 8'h01;
      end else if (state == adct_pkg::ADCT_RUN
                   && (!rc_mode || rc_tick_i)) begin
        cnt <= cnt + 8'h01;
      end
    end
  end

  // control bits: writes to select and source only while quiet
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      channel_select <= 2'h0;
      adc_rc_clock_select <= 1'b0;
    end else if (wr_en && paddr_i == adct_pkg::ADCT_CTRL_OFS
                 && !conv_start_busy && !conv_done_flag) begin
      channel_select <= pwdata_i[adct_pkg::ADCT_CH_LSB +: 2];
      adc_rc_clock_select <= pwdata_i[adct_pkg::ADCT_RCSEL_BIT];
    end
  end

  // busy, done and result; completion sets done as busy clears
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      conv_start_busy <= 1'b0;
      conv_done_flag <= 1'b0;
      conv_result_reg <= 8'h00;
    end else begin
      if (start_req) begin
        conv_start_busy <= 1'b1;
      end else if (finish || abort_pd) begin
        conv_start_busy <= 1'b0;
      end
      if (finish) begin
        conv_done_flag <= 1'b1;
        conv_result_reg <= sar_value;
      end else if (wr_en && paddr_i == adct_pkg::ADCT_CTRL_OFS
                   && !pwdata_i[adct_pkg::ADCT_DONE_BIT]) begin
        conv_done_flag <= 1'b0;  // cleared by software, set wins
      end
      if (abort_pd) begin
        conv_result_reg <= adct_pkg::ADCT_BAD_RESULT;
      end
    end
  end

  // sticky events, write one to clear, set wins
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_status <= 2'h0;
      irq_mask <= adct_pkg::ADCT_MASK_RST;
    end else begin
      if (wr_en && paddr_i == adct_pkg::ADCT_MASK_OFS) begin
        irq_mask <= pwdata_i[1:0];
      end
      irq_status <= (irq_status
        & ~((wr_en && paddr_i == adct_pkg::ADCT_STATUS_OFS)
            ? pwdata_i[1:0] : 2'h0))
        | {abort_pd, finish};
    end
  end

  // interrupt while any unmasked event stands
  assign irq_o = |(irq_status & irq_mask);
  // idle wake on enabled completion; no wake from an abort
  assign wake_o = idle_mode_i && !power_down_i
    && irq_status[adct_pkg::ADCT_EV_DONE]
    && irq_mask[adct_pkg::ADCT_EV_DONE];

  // read data register, unmapped reads return zero
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prdata_o <= 32'h0;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      case (paddr_i)
        adct_pkg::ADCT_CTRL_OFS:
          prdata_o <= {27'h0, conv_done_flag, conv_start_busy,
                       adc_rc_clock_select, channel_select};
        adct_pkg::ADCT_RESULT_OFS: prdata_o <= {24'h0, conv_result_reg};
        adct_pkg::ADCT_STATUS_OFS: prdata_o <= {30'h0, irq_status};
        adct_pkg::ADCT_MASK_OFS: prdata_o <= {30'h0, irq_mask};
        default: prdata_o <= 32'h0;
      endcase
    end
  end

  // approximation engine, stepped through the run phase
  adct_sar u_sar (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .load_i(start_req),
    .tick_i(state == adct_pkg::ADCT_RUN),
    .sample_i(sample),
    .value_o(sar_value)
  );
endmodule : adct_ctrl

/* tb/adct_props.sv */
// Purpose: port checker for the converter control block
// Assumes: one clock domain, apb slave answers with zero wait
// Notes: bound to every adct_ctrl instance at the foot of this file
`timescale 1ns/1ps
module adct_props (
  // clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // power state and events
  input wire logic idle_mode_i,
  input wire logic power_down_i,
  input wire logic wake_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);
  // completed write and read accesses
  wire logic wr = psel_i && penable_i && pwrite_i;
  wire logic rd = psel_i && penable_i && !pwrite_i;
  a_apb_zero_wait: assert property (pready_o && !pslverr_o)
    else $error("apb answer not ready or erroneous");
  a_wake_needs_idle: assert property (
    wake_o |-> idle_mode_i && irq_o)
    else $error("wake without idle or unmasked event");
  a_pd_no_wake: assert property (
    power_down_i |-> !wake_o)
    else $error("wake raised in power down");
  // only software may lower a raised event
  a_irq_sticky: assert property (irq_o && !wr |=> irq_o)
    else $error("irq dropped without a write");
  a_wake_sticky: assert property (
    wake_o && !wr ##1 idle_mode_i |-> wake_o)
    else $error("wake dropped while idle");
  a_mask_blocks_irq: assert property (
    wr && paddr_i == adct_pkg::ADCT_MASK_OFS && pwdata_i[1:0] == 2'h0
    |=> !irq_o)
    else $error("irq high with mask cleared");
  a_result_byte: assert property (
    rd && paddr_i == adct_pkg::ADCT_RESULT_OFS |-> prdata_o[31:8] == 0)
    else $error("result wider than a byte");
  // busy falls in the very cycle that done rises
  a_busy_done_excl: assert property (
    rd && paddr_i == adct_pkg::ADCT_CTRL_OFS
    |-> !(prdata_o[3] && prdata_o[4]))
    else $error("busy and done seen together");
endmodule : adct_props

bind adct_ctrl adct_props u_adct_props (
  .clock_i(clock_i),
  .rstn_i(rstn_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pwrite_i(pwrite_i),
  .paddr_i(paddr_i),
  .pwdata_i(pwdata_i),
  .prdata_o(prdata_o),
  .pready_o(pready_o),
  .pslverr_o(pslverr_o),
  .idle_mode_i(idle_mode_i),
  .power_down_i(power_down_i),
  .wake_o(wake_o),
  .irq_o(irq_o)
);

/* tb/adc_conversion_timing_ctrl_bench.sv */
// Purpose: register level test of the converter control block
// Assumes: apb zero wait, one machine cycle per clock
// Notes: rc ticks come from the wait loop, every other cycle
`timescale 1ns/1ps
module adc_conversion_timing_ctrl_bench;
  // design ports
  logic clock_i, rstn_i, psel_i, penable_i, pwrite_i;
  logic rc_tick_i, idle_mode_i, power_down_i;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i;
  wire logic [31:0] prdata_o;
  wire logic pready_o, pslverr_o, wake_o, irq_o;
  // fixed input words, distinct from the abort value
  localparam logic [7:0] AIN [4] = '{8'h3C, 8'h7D, 8'hBE, 8'hC2};
  wire logic [7:0] analog_in_0_i = AIN[0];
  wire logic [7:0] analog_in_1_i = AIN[1];
  wire logic [7:0] analog_in_2_i = AIN[2];
  wire logic [7:0] analog_in_3_i = AIN[3];
  // bench state
  logic [31:0] rd;
  logic rcm;
  int fail_count, cmp_count, n, k;
  adct_ctrl u_adct_ctrl (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .analog_in_0_i(analog_in_0_i),
    .analog_in_1_i(analog_in_1_i),
    .analog_in_2_i(analog_in_2_i),
    .analog_in_3_i(analog_in_3_i),
    .rc_tick_i(rc_tick_i),
    .idle_mode_i(idle_mode_i),
    .power_down_i(power_down_i),
    .wake_o(wake_o),
    .irq_o(irq_o)
  );
  // free running clock, far above the minimum cpu rate
  initial begin
    clock_i = 0;
    forever #10 clock_i = ~clock_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, request held until pready is sampled
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clock_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1;
    @(posedge clock_i);
    while (pready_o !== 1'b1) @(posedge clock_i);
    rd = prdata_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask : apb
  // counts edges and issued rc ticks until irq, bounded
  task automatic wait_irq;
    while (irq_o !== 1'b1 && n < 999) begin
      @(posedge clock_i);
      k += rc_tick_i;
      rc_tick_i <= rcm && n > 3 && n[0];
      n++;
      #1;
    end
    if (n >= 999) begin
      fail_count++;
      $display("unexpected at %0t: no interrupt in time", $time);
    end
    rc_tick_i <= 0;
  endtask : wait_irq
  task automatic finish_test;
    if (fail_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test
  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    #100000;
    fail_count++;
    finish_test;
  end
  initial begin
    {rstn_i, psel_i, penable_i, pwrite_i, rc_tick_i} = 0;
    {idle_mode_i, power_down_i, rcm, paddr_i, pwdata_i} = 0;
    {fail_count, cmp_count} = 0;
    repeat (4) @(posedge clock_i);
    rstn_i <= 1;
    // unmapped write must leave every register at reset value
    apb(1, 8'h10, '1);
    for (int a = 0; a < 4; a++) begin
      apb(0, 8'(a * 4), 0);
      chk(rd, 0);
    end
    apb(1, adct_pkg::ADCT_MASK_OFS, 32'h3);
    // cpu clocked conversion on every channel
    for (int c = 0; c < 4; c++) begin
      // nothing else can wake the cpu while it idles here
      idle_mode_i <= (c == 2);
      apb(1, adct_pkg::ADCT_CTRL_OFS, 32'(c + 8));
      n = 0;
      k = 0;
      if (c == 1) begin
        apb(1, adct_pkg::ADCT_CTRL_OFS, 32'h8);
        n = 3;
      end
      wait_irq;
      chk(n, 31);
      chk(wake_o, c == 2);
      apb(1, adct_pkg::ADCT_CTRL_OFS, 32'h1B);
      apb(0, adct_pkg::ADCT_CTRL_OFS, 0);
      chk(rd, 32'(c + 16));
      apb(0, adct_pkg::ADCT_RESULT_OFS, 0);
      chk(rd, 32'(AIN[c]));
      apb(0, adct_pkg::ADCT_STATUS_OFS, 0);
      chk(rd, 1);
      apb(1, adct_pkg::ADCT_CTRL_OFS, 0);
      apb(1, adct_pkg::ADCT_STATUS_OFS, 1);
      #1 chk(irq_o, 0);
    end
    // rc clocked conversion keeps running in power down
    // machine cycles are abstract; the modelled cpu stays slow enough
    rcm = 1;
    apb(1, adct_pkg::ADCT_CTRL_OFS, 32'h0C);
    power_down_i <= 1;
    n = 0;
    k = 0;
    wait_irq;
    chk(k, 108);
    chk(wake_o, 0);
    power_down_i <= 0;
    rcm = 0;
    apb(0, adct_pkg::ADCT_RESULT_OFS, 0);
    chk(rd, 32'(AIN[0]));
    apb(1, adct_pkg::ADCT_STATUS_OFS, 1);
    apb(1, adct_pkg::ADCT_CTRL_OFS, 0);
    apb(1, adct_pkg::ADCT_CTRL_OFS, 0);
    // power down on the cpu clock aborts without wake
    apb(1, adct_pkg::ADCT_CTRL_OFS, 32'h0B);
    power_down_i <= 1;
    repeat (3) @(posedge clock_i);
    #1 chk(irq_o, 1);
    chk(wake_o, 0);
    power_down_i <= 0;
    apb(0, adct_pkg::ADCT_RESULT_OFS, 0);
    chk(rd, 32'h000000FF);
    apb(0, adct_pkg::ADCT_CTRL_OFS, 0);
    chk(rd, 32'h3);
    apb(1, adct_pkg::ADCT_MASK_OFS, 0);
    #1 chk(irq_o, 0);
    apb(0, adct_pkg::ADCT_STATUS_OFS, 0);
    chk(rd, 32'h2);
    finish_test;
  end
endmodule : adc_conversion_timing_ctrl_bench
